//--- pkg/osic_pkg.sv
/*
 * constants, field layout and state codes for the operating-state and
 * interrupt-pin control block.
 * assumes a 250 MHz system clock; shared by every file of the block but the host model.
 */
package osic_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_OPSTATE_ADDR = 8'h07;   // operating_state_control
   localparam logic [7:0] REG_OPSTATE_RESET = 8'h00;  // value after reset
   localparam logic [7:0] OPSTATE_KEEP_MASK = 8'hF3;  // bits 3 and 2 never stored
   localparam int POS_IRQ_POLARITY = 7;               // irq_polarity_select
   localparam int POS_IRQ_DRIVE = 6;                  // irq_drive_style_select
   localparam int POS_WDT_HIGH = 5;                   // high_stall_watchdog_enable
   localparam int POS_WDT_LOW = 4;                    // low_stall_watchdog_enable
   localparam logic [1:0] SEL_IDLE = 2'h0;            // state_select_field: idle
   localparam logic [1:0] SEL_ACTIVE = 2'h1;          // state_select_field: active

   // ----------------------------------------------------------------
   // serial bus
   // ----------------------------------------------------------------
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;   // arbitrary bus address
   localparam logic [2:0] BIT_LAST = 3'h7;            // last bit of a byte
   localparam logic [2:0] BIT_RESET = 3'h0;           // bit counter after reset
   localparam logic [1:0] PIN_SYNC_RESET = 2'h3;      // idle bus reads high

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;               // 250 MHz
   localparam int WDT_TIMEOUT_US = 50;                // clock-line stall limit
   localparam int WDT_TIMEOUT_CYC = (WDT_TIMEOUT_US * 1000 * 1000) / CLK_PERIOD_PS;
   localparam int WDT_CNT_W = 16;                     // watchdog counter width
   localparam int IRQ_HOLD_NS = 1000;                 // least per-sample pulse
   localparam int IRQ_HOLD_CYC = (IRQ_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int IRQ_CNT_W = 9;                      // hold counter width

   // ----------------------------------------------------------------
   // receiver states, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [7:0] {
      RX_IDLE     = 8'h01,
      RX_ADDR     = 8'h02,
      RX_ADDR_ACK = 8'h04,
      RX_PTR      = 8'h08,
      RX_PTR_ACK  = 8'h10,
      RX_DATA     = 8'h20,
      RX_DATA_ACK = 8'h40,
      RX_SKIP     = 8'h80
   } osic_rx_state_t;

endpackage : osic_pkg

//--- rtl/osic_pin_sync.sv
/*
 * two-flop synchroniser for the serial clock and data pins.
 * assumes pins are asynchronous to clk_sys_in; bus idles high.
 */
`timescale 1ns/1ns
`default_nettype none
module osic_pin_sync
   import osic_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic [1:0] pins_in,
   output logic [1:0] pins_sync_out
);

   // ----------------------------------------------------------------
   // synchroniser stages
   // ----------------------------------------------------------------
   logic [1:0] meta_q;   // first stage, read only by second
   logic [1:0] meta_d;
   logic [1:0] sync_q;   // second stage
   logic [1:0] sync_d;

   // next values: plain shift
   always_comb begin
      meta_d = pins_in;
      sync_d = meta_q;
   end

   // registers, reset to idle-high
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         meta_q <= PIN_SYNC_RESET;
         sync_q <= PIN_SYNC_RESET;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign pins_sync_out = sync_q;

endmodule : osic_pin_sync
`default_nettype wire

//--- rtl/osic_evt_cross.sv
/*
 * toggle crossing of a one-cycle event from the sample clock domain
 * into the system domain.
 * assumes source pulses are spaced by more than three system cycles.
 */
`timescale 1ns/1ns
`default_nettype none
module osic_evt_cross
   import osic_pkg::*;
(
   input wire logic clk_src_in,
   input wire logic reset_src_in,
   input wire logic pulse_src_in,
   input wire logic clk_sys_in,
   input wire logic reset_in,
   output logic pulse_sys_out
);

   // ----------------------------------------------------------------
   // source side
   // ----------------------------------------------------------------
   logic tgl_q;   // flips once per event
   logic tgl_d;

   // next toggle value
   always_comb begin
      tgl_d = tgl_q ^ pulse_src_in;
   end

   // toggle register
   always_ff @(posedge clk_src_in) begin
      if (reset_src_in) begin
         tgl_q <= 1'b0;
      end else begin
         tgl_q <= tgl_d;
      end
   end

   // ----------------------------------------------------------------
   // destination side
   // ----------------------------------------------------------------
   logic s1_q;    // first stage, read only by s2
   logic s2_q;    // second stage
   logic s3_q;    // history for edge detect
   logic pls_q;   // output pulse
   logic s1_d;
   logic s2_d;
   logic s3_d;
   logic pls_d;

   // next values: shift and compare settled stages
   always_comb begin
      s1_d = tgl_q;
      s2_d = s1_q;
      s3_d = s2_q;
      pls_d = s2_q ^ s3_q;
   end

   // destination registers
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         pls_q <= 1'b0;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         pls_q <= pls_d;
      end
   end

   assign pulse_sys_out = pls_q;

endmodule : osic_evt_cross
`default_nettype wire

//--- rtl/osic_top.sv
/*
 * operating-state register behind a two-wire serial write port, bus
 * stall watchdogs and the interrupt pin driver with per-sample irq.
 * assumes the sample event comes from its own clock domain and that the
 * serial pins are asynchronous; the pad resolves the open-drain wires.
 */
`timescale 1ns/1ns
`default_nettype none
module osic_top
   import osic_pkg::*;
#(
   parameter int unsigned WDT_CYC = WDT_TIMEOUT_CYC,
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
)
(
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic clk_sample_in,
   input wire logic reset_sample_in,
   input wire logic sample_done_in,
   input wire logic sample_done_irq_enable_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   output logic interrupt_out_pin_out,
   output logic interrupt_out_pin_oe_out,
   output logic active_state_out,
   output logic watchdog_expired_out
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // decode of the state select field
   function automatic logic osic_is_active(input logic [1:0] sel);
      osic_is_active = (sel == SEL_ACTIVE);
   endfunction : osic_is_active

   localparam logic [WDT_CNT_W-1:0] WDT_LAST = WDT_CNT_W'(WDT_CYC - 1);
   localparam logic [IRQ_CNT_W-1:0] IRQ_HOLD = IRQ_CNT_W'(IRQ_HOLD_CYC);

   // ----------------------------------------------------------------
   // pin and event crossings
   // ----------------------------------------------------------------
   logic [1:0] pins_s;     // {scl, sda} synchronised
   logic scl_s;            // clock line, settled
   logic sda_s;            // data line, settled
   logic sample_evt;       // one pulse per finished sample

   osic_pin_sync u_pin_sync (
      .clk_sys_in(clk_sys_in),
      .reset_in(reset_in),
      .pins_in({scl_in, sda_in}),
      .pins_sync_out(pins_s)
   );

   osic_evt_cross u_evt_cross (
      .clk_src_in(clk_sample_in),
      .reset_src_in(reset_sample_in),
      .pulse_src_in(sample_done_in),
      .clk_sys_in(clk_sys_in),
      .reset_in(reset_in),
      .pulse_sys_out(sample_evt)
   );

   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   // ----------------------------------------------------------------
   // bus condition detect
   // ----------------------------------------------------------------
   logic scl_p_q;     // clock line one cycle ago
   logic sda_p_q;     // data line one cycle ago
   logic scl_rise;    // clock rising edge
   logic scl_fall;    // clock falling edge
   logic bus_start;   // data falls while clock high
   logic bus_stop;    // data rises while clock high

   // line history
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_p_q;
   assign scl_fall = ~scl_s & scl_p_q;
   assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign bus_stop = scl_s & scl_p_q & ~sda_p_q & sda_s;

   // ----------------------------------------------------------------
   // stall watchdog
   // ----------------------------------------------------------------
   logic [WDT_CNT_W-1:0] wd_q;   // cycles of clock line stuck
   logic [WDT_CNT_W-1:0] wd_d;
   logic wd_exp_q;               // timeout pulse, registered
   logic wd_exp_d;
   logic wd_count;               // stuck level is being watched
   logic wd_fire;                // limit reached this cycle
   osic_rx_state_t st_q;         // receiver state
   logic [7:0] opst_q;           // operating_state_control

   // only the enabled level of the clock line is timed
   assign wd_count = (st_q != RX_IDLE) & ~scl_rise & ~scl_fall &
                     ((~scl_s & opst_q[POS_WDT_LOW]) |
                      (scl_s & opst_q[POS_WDT_HIGH]));
   assign wd_fire = wd_count & (wd_q == WDT_LAST);

   // next watchdog values
   always_comb begin
      wd_d = '0;
      wd_exp_d = wd_fire;
      if (wd_count && !wd_fire) begin
         // still stuck: keep counting
         wd_d = WDT_CNT_W'(wd_q + 1'b1);
      end
   end

   // watchdog registers
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         wd_q <= '0;
         wd_exp_q <= 1'b0;
      end else begin
         wd_q <= wd_d;
         wd_exp_q <= wd_exp_d;
      end
   end

   // ----------------------------------------------------------------
   // serial receiver and state register
   // ----------------------------------------------------------------
   osic_rx_state_t st_d;
   logic [2:0] bit_q;      // bits taken in current byte
   logic [2:0] bit_d;
   logic [7:0] shift_q;    // incoming byte, msb first
   logic [7:0] shift_d;
   logic full_q;           // eight bits are in
   logic full_d;
   logic [7:0] ptr_q;      // register pointer, auto-increment
   logic [7:0] ptr_d;
   logic oe_q;             // data line pulled low for ack
   logic oe_d;
   logic [7:0] opst_d;
   logic receiving;        // a byte state is active
   logic wr_fire;          // data byte lands in the state register

   assign receiving = (st_q == RX_ADDR) | (st_q == RX_PTR) | (st_q == RX_DATA);
   // writes are taken whatever the operating state is
   assign wr_fire = scl_fall & full_q & (st_q == RX_DATA) & ~wd_fire &
                    ~bus_start & ~bus_stop & (ptr_q == REG_OPSTATE_ADDR);

   // next receiver values
   always_comb begin
      st_d = st_q;
      bit_d = bit_q;
      shift_d = shift_q;
      full_d = full_q;
      ptr_d = ptr_q;
      oe_d = oe_q;
      opst_d = opst_q;
      if (wd_fire) begin
         // stall: drop the transfer, free the data line
         st_d = RX_IDLE;
         oe_d = 1'b0;
         full_d = 1'b0;
      end else if (bus_start) begin
         // start or repeated start
         st_d = RX_ADDR;
         bit_d = BIT_RESET;
         full_d = 1'b0;
         oe_d = 1'b0;
      end else if (bus_stop) begin
         // end of frame
         st_d = RX_IDLE;
         oe_d = 1'b0;
         full_d = 1'b0;
      end else begin
         if (scl_rise && receiving) begin
            // take one bit
            shift_d = {shift_q[6:0], sda_s};
            bit_d = 3'(bit_q + 1'b1);
            full_d = (bit_q == BIT_LAST);
         end
         if (scl_fall) begin
            case (st_q)
               RX_ADDR: begin
                  // address byte: ack writes to us only
                  if (full_q) begin
                     full_d = 1'b0;
                     if (shift_q[7:1] == DEV_ADDR && !shift_q[0]) begin
                        st_d = RX_ADDR_ACK;
                        oe_d = 1'b1;
                     end else begin
                        st_d = RX_SKIP;
                     end
                  end
               end
               RX_PTR: begin
                  // register pointer byte
                  if (full_q) begin
                     full_d = 1'b0;
                     ptr_d = shift_q;
                     st_d = RX_PTR_ACK;
                     oe_d = 1'b1;
                  end
               end
               RX_DATA: begin
                  // data byte: store if aimed at us
                  if (full_q) begin
                     full_d = 1'b0;
                     if (wr_fire) begin
                        opst_d = shift_q & OPSTATE_KEEP_MASK;
                     end
                     ptr_d = 8'(ptr_q + 1'b1);
                     st_d = RX_DATA_ACK;
                     oe_d = 1'b1;
                  end
               end
               RX_ADDR_ACK: begin
                  // ack clock over
                  oe_d = 1'b0;
                  st_d = RX_PTR;
               end
               RX_PTR_ACK, RX_DATA_ACK: begin
                  // ack clock over
                  oe_d = 1'b0;
                  st_d = RX_DATA;
               end
               default: begin
                  // idle or skipping: nothing to do
                  st_d = st_q;
               end
            endcase
         end
      end
   end

   // receiver registers
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         st_q <= RX_IDLE;
         bit_q <= BIT_RESET;
         shift_q <= '0;
         full_q <= 1'b0;
         ptr_q <= '0;
         oe_q <= 1'b0;
         opst_q <= REG_OPSTATE_RESET;
      end else begin
         st_q <= st_d;
         bit_q <= bit_d;
         shift_q <= shift_d;
         full_q <= full_d;
         ptr_q <= ptr_d;
         oe_q <= oe_d;
         opst_q <= opst_d;
      end
   end

   // ----------------------------------------------------------------
   // per-sample interrupt and pin driver
   // ----------------------------------------------------------------
   logic [IRQ_CNT_W-1:0] hold_q;   // cycles left of asserted irq
   logic [IRQ_CNT_W-1:0] hold_d;
   logic pin_q;                    // pin output level
   logic pin_d;
   logic pin_oe_q;                 // pin driven
   logic pin_oe_d;
   logic act_q;                    // active operating state
   logic act_d;
   logic sda_q;                    // data line drive level
   logic level;                    // wanted pin level

   // next irq and pin values
   always_comb begin
      hold_d = hold_q;
      if (!sample_done_irq_enable_in) begin
         hold_d = '0;
      end else if (sample_evt) begin
         hold_d = IRQ_HOLD;
      end else if (hold_q != '0) begin
         hold_d = IRQ_CNT_W'(hold_q - 1'b1);
      end
      // asserted shows the polarity bit, idle its inverse
      level = (hold_q != '0) ? opst_q[POS_IRQ_POLARITY] : ~opst_q[POS_IRQ_POLARITY];
      if (opst_q[POS_IRQ_DRIVE]) begin
         // push-pull: drive both levels
         pin_d = level;
         pin_oe_d = 1'b1;
      end else begin
         // open drain: only pull low
         pin_d = 1'b0;
         pin_oe_d = ~level;
      end
      act_d = osic_is_active(opst_q[1:0]);
   end

   // irq and pin registers
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         hold_q <= '0;
         pin_q <= 1'b0;
         pin_oe_q <= 1'b0;
         act_q <= 1'b0;
         sda_q <= 1'b0;
      end else begin
         hold_q <= hold_d;
         pin_q <= pin_d;
         pin_oe_q <= pin_oe_d;
         act_q <= act_d;
         sda_q <= 1'b0;
      end
   end

   assign sda_out = sda_q;
   assign sda_oe_out = oe_q;
   assign interrupt_out_pin_out = pin_q;
   assign interrupt_out_pin_oe_out = pin_oe_q;
   assign active_state_out = act_q;
   assign watchdog_expired_out = wd_exp_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);

   sequence s_wd_fire;
      wd_fire;
   endsequence
   sequence s_released;
      (st_q == RX_IDLE) && !sda_oe_out && watchdog_expired_out;
   endsequence
   sequence s_sample_on;
      sample_evt && sample_done_irq_enable_in;
   endsequence

   chk_sample_irq_set: assert property (s_sample_on |=> hold_q == IRQ_HOLD)
      else $error("sample irq not raised");
   chk_irq_quiet_off: assert property (!sample_done_irq_enable_in |=> hold_q == '0)
      else $error("irq held while disabled");
   chk_write_any_state: assert property (wr_fire |=> opst_q == ($past(shift_q) & OPSTATE_KEEP_MASK))
      else $error("state register write lost");
   chk_state_decode: assert property (wr_fire && shift_q[1:0] == SEL_ACTIVE |=> ##1 active_state_out)
      else $error("active code not decoded");
   chk_wdt_low_fire: assert property (wd_count && !scl_s && wd_q == WDT_LAST |-> opst_q[POS_WDT_LOW] ##1 st_q == RX_IDLE)
      else $error("low stall watchdog wrong");
   chk_wdt_high_fire: assert property (wd_count && scl_s && wd_q == WDT_LAST |-> opst_q[POS_WDT_HIGH] ##1 st_q == RX_IDLE)
      else $error("high stall watchdog wrong");
   chk_od_no_high: assert property (!opst_q[POS_IRQ_DRIVE] |=> !(interrupt_out_pin_oe_out && interrupt_out_pin_out))
      else $error("open drain drove high");
   chk_pp_drive: assert property (opst_q[POS_IRQ_DRIVE] |=> interrupt_out_pin_oe_out)
      else $error("push-pull pin released");
   chk_pol_low: assert property (hold_q != '0 && !opst_q[POS_IRQ_POLARITY] |=> interrupt_out_pin_oe_out && !interrupt_out_pin_out)
      else $error("active low irq not low");
   chk_wdt_release: assert property (s_wd_fire |=> s_released)
      else $error("watchdog did not release bus");

endmodule : osic_top
`default_nettype wire

//--- bench/osic_host_model.sv
/*
 * host model: open-drain two-wire bus master writing the device.
 * assumes the bench resolves both wires with pull-ups.
 */
`timescale 1ns/1ns
`default_nettype none
module osic_host_model (
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_low_out,
   output logic sda_low_out
);
   // ---------------------------------------------
   // bus phases, half period of ten clocks
   // ---------------------------------------------
   initial begin
      scl_low_out = 1'b0;
      sda_low_out = 1'b0;
   end
   task hp(input int n);
      repeat (n) @(posedge clk_in);
   endtask : hp
   // start: data falls while clock is high
   task start;
      sda_low_out <= 1'b1;
      hp(10);
      scl_low_out <= 1'b1;
      hp(10);
   endtask : start
   // stop: data rises while clock is high
   task stop;
      sda_low_out <= 1'b1;
      hp(10);
      scl_low_out <= 1'b0;
      hp(10);
      sda_low_out <= 1'b0;
      hp(10);
   endtask : stop
   // msb first, ninth clock samples the ack
   task send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= -1; i--) begin
         if (i >= 0) sda_low_out <= ~b[i];
         else sda_low_out <= 1'b0;
         hp(10);
         scl_low_out <= 1'b0;
         hp(5);
         ack = ~sda_in;
         hp(5);
         scl_low_out <= 1'b1;
         hp(2);
      end
   endtask : send_byte
   // whole write frame; bit two of the data byte always sent as zero
   task write(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d, output logic [2:0] acks);
      start();
      send_byte(a, acks[2]);
      send_byte(p, acks[1]);
      send_byte(d & 8'hFB, acks[0]);
      stop();
   endtask : write
   // address byte, then the clock line stands still for n clocks in its
   // ack clock; held tells whether the device still pulls data low then
   task stall(input logic [7:0] a, input logic hi, input int n, output logic held);
      start();
      for (int i = 7; i >= 0; i--) begin
         sda_low_out <= ~a[i];
         hp(10);
         scl_low_out <= 1'b0;
         hp(10);
         scl_low_out <= 1'b1;
         hp(2);
      end
      sda_low_out <= 1'b0;
      hp(10);
      scl_low_out <= ~hi;
      hp(n);
      held = ~sda_in;
      scl_low_out <= 1'b0;
      hp(10);
      scl_low_out <= 1'b1;
      hp(10);
      stop();
   endtask : stall
endmodule : osic_host_model
`default_nettype wire

//--- bench/tb.sv
/*
 * testbench: state register, irq pin styles, watchdogs, refusals.
 * assumes the host model and the design package are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module tb
   import osic_pkg::*;
;
   // ---------------------------------------------
   // signals and design under test
   // ---------------------------------------------
   localparam int WD = 40; // short watchdog count
   localparam logic [7:0] ADDR_W = {DEV_ADDR_DEFAULT, 1'b0};
   typedef struct packed {logic [7:0] mode; logic en; logic act;} osic_row_t;
   osic_row_t rows [8] = '{'{8'h00, 1'b1, 1'b0}, '{8'h01, 1'b1, 1'b1}, '{8'h80, 1'b1, 1'b0},
      '{8'h40, 1'b1, 1'b0}, '{8'h81, 1'b1, 1'b1}, '{8'h41, 1'b1, 1'b1}, '{8'hC0, 1'b1, 1'b0},
      '{8'h01, 1'b0, 1'b1}};
   logic [7:0] wd_mode [4] = '{8'h10, 8'h10, 8'h20, 8'h20};
   logic wd_hi [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
   int wd_exp [4] = '{1, 0, 1, 0};
   logic clk_sys = 1'b0;
   logic clk_smp = 1'b0;
   logic reset = 1'b1;
   logic reset_smp = 1'b1;
   logic smp_done = 1'b0;
   logic irq_en = 1'b0;
   logic sda_o, sda_oe, irq_o, irq_oe, active, wd, scl_low, sda_low;
   logic [2:0] acks;
   logic held; // device still acking after a stall
   int err_count = 0;
   int n_compared = 0;
   int wd_count = 0;
   int wd_seen;
   wire logic scl_w = ~scl_low; // pull-up
   wire logic sda_w = ~(sda_low | (sda_oe & ~sda_o)); // pull-up
   osic_top #(.WDT_CYC(WD), .DEV_ADDR(DEV_ADDR_DEFAULT)) i_dut (.clk_sys_in(clk_sys), .reset_in(reset),
      .clk_sample_in(clk_smp), .reset_sample_in(reset_smp), .sample_done_in(smp_done),
      .sample_done_irq_enable_in(irq_en), .scl_in(scl_w), .sda_in(sda_w), .sda_out(sda_o),
      .sda_oe_out(sda_oe), .interrupt_out_pin_out(irq_o), .interrupt_out_pin_oe_out(irq_oe),
      .active_state_out(active), .watchdog_expired_out(wd));
   osic_host_model i_host (.clk_in(clk_sys), .sda_in(sda_w), .scl_low_out(scl_low), .sda_low_out(sda_low));
   // 4 ns system clock, 12 ns sample clock at an odd phase
   initial forever #2 clk_sys = ~clk_sys;
   initial begin
      #3;
      forever #6 clk_smp = ~clk_smp;
   end
   // counts watchdog pulses
   always @(posedge clk_sys) if (wd === 1'b1) wd_count <= wd_count + 1;
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   // expected {oe, out} of the irq pin
   function automatic logic [1:0] pin_exp(input logic [7:0] m, input logic asrt);
      logic lvl;
      lvl = asrt ? m[POS_IRQ_POLARITY] : ~m[POS_IRQ_POLARITY];
      return m[POS_IRQ_DRIVE] ? {1'b1, lvl} : {~lvl, 1'b0};
   endfunction : pin_exp
   task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task pulse;
      @(posedge clk_smp);
      smp_done <= 1'b1;
      @(posedge clk_smp);
      smp_done <= 1'b0;
   endtask : pulse
   task report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   // ---------------------------------------------
   // sequence
   // ---------------------------------------------
   initial begin
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      reset_smp <= 1'b0;
      @(negedge clk_sys);
      chk("active", 8'h00, 8'(active));
      chk("pin rst", 8'h00, 8'({irq_oe, irq_o}));
      repeat (5) @(posedge clk_sys);
      // table: legal state codes, drive style and polarity
      foreach (rows[i]) begin
         @(posedge clk_sys);
         irq_en <= rows[i].en;
         i_host.write(ADDR_W, REG_OPSTATE_ADDR, rows[i].mode, acks);
         @(negedge clk_sys);
         chk("acks", 8'h07, 8'(acks));
         chk("active", 8'(rows[i].act), 8'(active));
         chk("pin idle", 8'(pin_exp(rows[i].mode, 1'b0)), 8'({irq_oe, irq_o}));
         pulse();
         repeat (12) @(posedge clk_sys);
         @(negedge clk_sys);
         chk("pin set", 8'(pin_exp(rows[i].mode, rows[i].en)), 8'({irq_oe, irq_o}));
         repeat (260) @(posedge clk_sys);
         @(negedge clk_sys);
         chk("pin clear", 8'(pin_exp(rows[i].mode, 1'b0)), 8'({irq_oe, irq_o}));
      end
      // refused: read, foreign address, other pointer
      i_host.write({DEV_ADDR_DEFAULT, 1'b1}, REG_OPSTATE_ADDR, 8'h00, acks);
      chk("read acks", 8'h00, 8'(acks));
      i_host.write({DEV_ADDR_DEFAULT ^ 7'h01, 1'b0}, REG_OPSTATE_ADDR, 8'h00, acks);
      chk("addr acks", 8'h00, 8'(acks));
      i_host.write(ADDR_W, 8'h08, 8'h00, acks);
      @(negedge clk_sys);
      chk("ptr acks", 8'h07, 8'(acks));
      chk("active kept", 8'h01, 8'(active));
      // watchdogs enabled and disabled, recovery after timeout
      for (int k = 0; k < 4; k++) begin
         i_host.write(ADDR_W, REG_OPSTATE_ADDR, wd_mode[k], acks);
         chk("wd acks", 8'h07, 8'(acks));
         wd_seen = wd_count;
         i_host.stall(ADDR_W, wd_hi[k], 3 * WD, held);
         @(negedge clk_sys);
         chk("watchdog", 8'(wd_exp[k]), 8'(wd_count - wd_seen));
         chk("sda oe", 8'h00, 8'(sda_oe));
         chk("ack held", 8'(wd_exp[k] == 0), 8'(held));
      end
      // reset in mid-run
      i_host.write(ADDR_W, REG_OPSTATE_ADDR, 8'h01, acks);
      @(posedge clk_sys);
      reset <= 1'b1;
      reset_smp <= 1'b1;
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      reset_smp <= 1'b0;
      @(negedge clk_sys);
      chk("active rst", 8'h00, 8'(active));
      chk("pin rst", 8'h00, 8'({irq_oe, irq_o}));
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
